// *** logic/pvsc_pkg.sv ***
// Shared constants, types and register map of the frame-sync and offset-trim register bank.
package pvsc_pkg;

    // ----------------------------------------------------------------
    // Register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SYNC_DELAY_LOW   = 8'h4F;
    localparam logic [7:0] ADDR_SYNC_DELAY_HIGH  = 8'h50;
    localparam logic [7:0] ADDR_FRAME_SYNC_CFG0  = 8'h53;
    localparam logic [7:0] ADDR_FRAME_SYNC_FREQ  = 8'h54;
    localparam logic [7:0] ADDR_FIRST_BURST_DLY  = 8'h56;
    localparam logic [7:0] ADDR_SECOND_BURST_DLY = 8'h57;
    localparam logic [7:0] ADDR_OFFSET_TRIM_CTRL = 8'h69;
    localparam logic [7:0] ADDR_OFFSET_LOW       = 8'hC7;
    localparam logic [7:0] ADDR_OFFSET_HIGH      = 8'hC8;

    localparam logic [14:0] RST_SYNC_DELAY       = 15'h0000;
    localparam logic [5:0]  RST_FRAME_RATE_CODE  = 6'h10;
    localparam logic [7:0]  RST_BURST_DELAY      = 8'h00;
    localparam logic [3:0]  CFG0_RESERVED_HIGH   = 4'h1;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG0_LL_BYPASS_BIT  = 3;
    localparam int CFG0_TRIM_MODE_LSB  = 0;
    localparam int TRIM_START_BIT      = 0;
    localparam int SYNC_HIGH_BITS      = 7;

    // ----------------------------------------------------------------
    // Frame rate conversion and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] FREQ_BASE_HZ   = 8'h1C;
    localparam logic [7:0] FREQ_STEP_HZ   = 8'h02;
    localparam int CORE_CLK_MHZ           = 100;
    localparam int TRIM_STEP_NS           = 1000;
    localparam int TRIM_STEP_CYCLES       = (TRIM_STEP_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int OFFSET_BITS            = 9;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PVSC_OSC_NONE   = 2'h0,
        PVSC_OSC_SINGLE = 2'h1,
        PVSC_OSC_ALWAYS = 2'h2,
        PVSC_OSC_RSVD   = 2'h3
    } pvsc_osc_mode_t;

    typedef enum logic [1:0] {
        PVSC_TRIM_IDLE   = 2'b00,
        PVSC_TRIM_SETTLE = 2'b01,
        PVSC_TRIM_DECIDE = 2'b11,
        PVSC_TRIM_FINISH = 2'b10
    } pvsc_trim_state_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pvsc_reg_req_t;

    typedef struct packed {
        logic       write;
        logic [7:0] low;
        logic [7:0] high;
    } pvsc_offset_wr_t;

endpackage

// *** logic/pvsc_trim_engine.sv ***
// Offset trim engine: binary search of the proximity offset against a comparator.
`timescale 1ns/1ps

module pvsc_trim_engine #(
    parameter int STEP_CYCLES = pvsc_pkg::TRIM_STEP_CYCLES
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      start,
    input  wire logic                      cmpHigh,
    output logic                           busy,
    output logic                           done,
    output logic [pvsc_pkg::OFFSET_BITS-1:0] trialOffset,
    output pvsc_pkg::pvsc_offset_wr_t      result
);
    import pvsc_pkg::*;

    // The settle timer is sixteen bits wide, so longer steps cannot be counted.
    if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_bad_step
        $error("STEP_CYCLES out of range");
    end

    typedef struct packed {
        pvsc_trim_state_t       st;
        logic [3:0]             bitIdx;
        logic [15:0]            timer;
        logic [OFFSET_BITS-1:0] trial;
        logic                   busy;
        logic                   done;
        pvsc_offset_wr_t        result;
    } pvsc_eng_state_t;

    pvsc_eng_state_t s;
    pvsc_eng_state_t next_s;

    // ----------------------------------------------------------------
    // Search sequencer
    // ----------------------------------------------------------------
    // A dropped start aborts in the settle or decide state without touching the result.
    always_comb begin
        next_s              = s;
        next_s.done         = 1'b0;
        next_s.result.write = 1'b0;
        case (s.st)
            PVSC_TRIM_IDLE: begin
                if (start) begin
                    next_s.st     = PVSC_TRIM_SETTLE;
                    next_s.bitIdx = 4'(OFFSET_BITS - 1);
                    next_s.trial  = {1'b1, {(OFFSET_BITS-1){1'b0}}};
                    next_s.timer  = 16'(STEP_CYCLES - 1);
                    next_s.busy   = 1'b1;
                end
            end
            PVSC_TRIM_SETTLE: begin
                if (s.timer == 16'h0000) begin
                    next_s.st = PVSC_TRIM_DECIDE;
                end else begin
                    next_s.timer = s.timer - 16'h0001;
                end
            end
            PVSC_TRIM_DECIDE: begin
                next_s.trial[s.bitIdx] = cmpHigh;
                if (s.bitIdx == 4'h0) begin
                    next_s.st            = PVSC_TRIM_FINISH;
                    next_s.busy          = 1'b0;
                    next_s.done          = 1'b1;
                    next_s.result.write  = 1'b1;                        // [R6]
                    next_s.result.low    = next_s.trial[7:0];           // [R6]
                    next_s.result.high   = {7'h00, next_s.trial[8]};    // [R6]
                end else begin
                    next_s.bitIdx             = s.bitIdx - 4'h1;
                    next_s.trial[s.bitIdx-1]  = 1'b1;
                    next_s.timer              = 16'(STEP_CYCLES - 1);
                    next_s.st                 = PVSC_TRIM_SETTLE;
                end
            end
            PVSC_TRIM_FINISH: begin
                // Waits for the start bit to fall so a finished run never relaunches itself.
                if (!start) begin
                    next_s.st = PVSC_TRIM_IDLE;
                end
            end
            default: begin
                next_s.st = PVSC_TRIM_IDLE;
            end
        endcase
        if (!start && (s.st == PVSC_TRIM_SETTLE || s.st == PVSC_TRIM_DECIDE)) begin
            next_s.st           = PVSC_TRIM_IDLE;                       // [R9]
            next_s.busy         = 1'b0;                                 // [R9]
            next_s.done         = 1'b0;
            next_s.result.write = 1'b0;
            next_s.result.low   = s.result.low;
            next_s.result.high  = s.result.high;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy        = s.busy;
    assign done        = s.done;
    assign trialOffset = s.trial;
    assign result      = s.result;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_result_on_done;
        @(posedge core_clk) disable iff (rst)
        done |-> result.write && result.high[7:1] == 7'h00 && !busy;
    endproperty
    a_result_on_done: assert property (p_result_on_done) // [R6]
        else $error("Offset result not written on completion.");

endmodule

// *** logic/pvsc_regs.sv ***
// Frame-sync configuration and offset-trim control register bank.
`timescale 1ns/1ps

// Summary of operation
// R1: Frame rate is 28 Hz plus 2 Hz per code.
// R2: Trim mode picks none, single, continuous, reserved.
// R3: First burst start delay register, resets zero.
// R4: Second burst start delay register, resets zero.
// R5: Writing one to start bit launches trim.
// R6: Trim writes offset result to C7 and C8.
// R7: Done flag rises when trim completes.
// R8: Interrupt rises on completion only when enabled.
// R9: Writing zero to start aborts trim immediately.
// R10: Sync delay is fifteen bits over two addresses.
// R11: Reserved bits read reset value, writes ignored.
module pvsc_regs (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  pvsc_pkg::pvsc_reg_req_t        regReq,
    output logic [7:0]                     regRdData,
    input  wire logic                      powerOnBit,
    input  wire logic                      oscTrimIdle,
    input  wire logic                      trimDoneInterruptEnable,
    input  wire logic                      trimDoneFlagClear,
    input  wire logic                      offsetCmpHigh,
    output logic [14:0]                    syncDelay,
    output logic                           frameRateLowLimitBypass,
    output logic [1:0]                     oscillatorTrimMode,
    output logic [5:0]                     frameRateCode,
    output logic [7:0]                     frameRateHz,
    output logic [7:0]                     firstBurstStartDelay,
    output logic [7:0]                     secondBurstStartDelay,
    output logic                           oscTrimRequest,
    output logic                           offsetTrimActive,
    output logic [pvsc_pkg::OFFSET_BITS-1:0] offsetTrial,
    output pvsc_pkg::pvsc_offset_wr_t      offsetResult,
    output logic                           offsetTrimDoneFlag,
    output logic                           trimDoneInterrupt
);
    import pvsc_pkg::*;

    typedef struct packed {
        logic [14:0] syncDelay;
        logic        llBypass;
        logic [1:0]  trimMode;
        logic [5:0]  frameRateCode;
        logic [7:0]  frameRateHz;
        logic [7:0]  firstDelay;
        logic [7:0]  secondDelay;
        logic        trimStart;
        logic        doneFlag;
        logic        doneIrq;
        logic [7:0]  rdData;
        logic        oscReq;
        logic        singleArmed;
        logic        powerOnMeta;
        logic        powerOnSync;
        logic        powerOnPrev;
        logic        cmpMeta;
        logic        cmpSync;
    } pvsc_regs_state_t;

    pvsc_regs_state_t s;
    pvsc_regs_state_t next_s;

    logic            engBusy;
    logic            engDone;
    logic [OFFSET_BITS-1:0] engTrial;
    pvsc_offset_wr_t engResult;

    logic wrHit;
    logic rdHit;
    assign wrHit = regReq.write;
    assign rdHit = regReq.read;

    // ----------------------------------------------------------------
    // Register file, trim control and oscillator trim requests
    // ----------------------------------------------------------------
    // Everything is written in one pass so that a hardware set and a host
    // clear in the same cycle resolve in a single, visible priority order.
    always_comb begin
        next_s = s;
        // Front-end comparator and power-on bit arrive from other logic domains.
        next_s.cmpMeta     = offsetCmpHigh;
        next_s.cmpSync     = s.cmpMeta;
        next_s.powerOnMeta = powerOnBit;
        next_s.powerOnSync = s.powerOnMeta;
        next_s.powerOnPrev = s.powerOnSync;

        if (wrHit) begin
            case (regReq.addr)
                ADDR_SYNC_DELAY_LOW: begin
                    next_s.syncDelay[7:0] = regReq.wrData;                           // [R10]
                end
                ADDR_SYNC_DELAY_HIGH: begin
                    next_s.syncDelay[14:8] = regReq.wrData[SYNC_HIGH_BITS-1:0];      // [R10]
                end
                ADDR_FRAME_SYNC_CFG0: begin
                    next_s.llBypass = regReq.wrData[CFG0_LL_BYPASS_BIT];             // [R11]
                    next_s.trimMode = regReq.wrData[CFG0_TRIM_MODE_LSB +: 2];        // [R2]
                end
                ADDR_FRAME_SYNC_FREQ: begin
                    next_s.frameRateCode = regReq.wrData[5:0];                       // [R11]
                end
                ADDR_FIRST_BURST_DLY: begin
                    next_s.firstDelay = regReq.wrData;                               // [R3]
                end
                ADDR_SECOND_BURST_DLY: begin
                    next_s.secondDelay = regReq.wrData;                              // [R4]
                end
                ADDR_OFFSET_TRIM_CTRL: begin
                    // A zero here aborts a run in progress; a one launches a new run.
                    next_s.trimStart = regReq.wrData[TRIM_START_BIT];                // [R5] [R9]
                end
                default: begin
                    next_s.trimStart = s.trimStart;
                end
            endcase
        end

        // Start bit self-clears once the engine reports completion.
        if (engDone) begin
            next_s.trimStart = 1'b0;
        end

        // Frame rate in hertz is registered together with the code it follows.
        next_s.frameRateHz = FREQ_BASE_HZ + FREQ_STEP_HZ * {2'b00, next_s.frameRateCode}; // [R1]

        // Done flag: a fresh start or an outside clear drops it; completion wins over both.
        if (trimDoneFlagClear || (wrHit && regReq.addr == ADDR_OFFSET_TRIM_CTRL
                && regReq.wrData[TRIM_START_BIT])) begin
            next_s.doneFlag = 1'b0;
        end
        if (engDone) begin
            next_s.doneFlag = 1'b1;                                                  // [R7]
        end
        next_s.doneIrq = next_s.doneFlag && trimDoneInterruptEnable;                 // [R8]

        // Oscillator trim: single shot after power-on rises, or whenever the oscillator is free.
        if (s.powerOnSync && !s.powerOnPrev) begin
            next_s.singleArmed = 1'b1;
        end
        case (pvsc_osc_mode_t'(s.trimMode))
            PVSC_OSC_SINGLE: begin
                next_s.oscReq = s.singleArmed;                                       // [R2]
                if (s.singleArmed) begin
                    next_s.singleArmed = 1'b0;
                end
            end
            PVSC_OSC_ALWAYS: begin
                next_s.oscReq = oscTrimIdle;                                         // [R2]
            end
            default: begin
                // Reserved mode behaves as no calibration so a bad write stays harmless.
                next_s.oscReq = 1'b0;                                                // [R2]
            end
        endcase

        // Read path, one cycle of latency; unmapped addresses read zero.
        if (rdHit) begin
            case (regReq.addr)
                ADDR_SYNC_DELAY_LOW:   next_s.rdData = s.syncDelay[7:0];
                ADDR_SYNC_DELAY_HIGH:  next_s.rdData = {1'b0, s.syncDelay[14:8]};    // [R10]
                ADDR_FRAME_SYNC_CFG0:  next_s.rdData = {CFG0_RESERVED_HIGH, s.llBypass,
                                                        1'b0, s.trimMode};           // [R11]
                ADDR_FRAME_SYNC_FREQ:  next_s.rdData = {2'b00, s.frameRateCode};     // [R11]
                ADDR_FIRST_BURST_DLY:  next_s.rdData = s.firstDelay;
                ADDR_SECOND_BURST_DLY: next_s.rdData = s.secondDelay;
                ADDR_OFFSET_TRIM_CTRL: next_s.rdData = {7'h00, s.trimStart};
                default:               next_s.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s               <= '0;
            s.frameRateCode <= RST_FRAME_RATE_CODE;                                  // [R1]
            s.frameRateHz   <= FREQ_BASE_HZ + FREQ_STEP_HZ * {2'b00, RST_FRAME_RATE_CODE};
            s.firstDelay    <= RST_BURST_DELAY;                                      // [R3]
            s.secondDelay   <= RST_BURST_DELAY;                                      // [R4]
            s.syncDelay     <= RST_SYNC_DELAY;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Offset trim engine
    // ----------------------------------------------------------------
    pvsc_trim_engine u_engine (
        .core_clk    (core_clk),
        .rst         (rst),
        .start       (s.trimStart),
        .cmpHigh     (s.cmpSync),
        .busy        (engBusy),
        .done        (engDone),
        .trialOffset (engTrial),
        .result      (engResult)
    );

    assign regRdData               = s.rdData;
    assign syncDelay               = s.syncDelay;
    assign frameRateLowLimitBypass = s.llBypass;
    assign oscillatorTrimMode      = s.trimMode;
    assign frameRateCode           = s.frameRateCode;
    assign frameRateHz             = s.frameRateHz;
    assign firstBurstStartDelay    = s.firstDelay;
    assign secondBurstStartDelay   = s.secondDelay;
    assign oscTrimRequest          = s.oscReq;
    assign offsetTrimActive        = engBusy;
    assign offsetTrial             = engTrial;
    assign offsetResult            = engResult;
    assign offsetTrimDoneFlag      = s.doneFlag;
    assign trimDoneInterrupt       = s.doneIrq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_freq;
        @(posedge core_clk) disable iff (rst)
        frameRateHz == 8'(8'd28 + 8'd2 * {2'b00, frameRateCode});
    endproperty
    a_freq: assert property (p_freq) // [R1]
        else $error("Frame rate does not follow the code.");

    property p_osc_single;
        @(posedge core_clk) disable iff (rst)
        (oscillatorTrimMode == 2'h1 && s.singleArmed) |=> oscTrimRequest ##1 !oscTrimRequest;
    endproperty
    a_osc_single: assert property (p_osc_single) // [R2]
        else $error("Single oscillator trim request is not one cycle.");

    property p_first_delay;
        @(posedge core_clk) disable iff (rst)
        (regReq.write && regReq.addr == 8'h56) |=> firstBurstStartDelay == $past(regReq.wrData);
    endproperty
    a_first_delay: assert property (p_first_delay) // [R3]
        else $error("First burst delay not stored.");

    property p_second_delay;
        @(posedge core_clk) disable iff (rst)
        (regReq.write && regReq.addr == 8'h57) |=> secondBurstStartDelay == $past(regReq.wrData);
    endproperty
    a_second_delay: assert property (p_second_delay) // [R4]
        else $error("Second burst delay not stored.");

    property p_launch;
        @(posedge core_clk) disable iff (rst)
        (regReq.write && regReq.addr == 8'h69 && regReq.wrData[0] && !offsetTrimActive
            && !s.trimStart) |=> ##1 offsetTrimActive;
    endproperty
    a_launch: assert property (p_launch) // [R5]
        else $error("Trim did not start two cycles after the start write.");

    property p_abort;
        @(posedge core_clk) disable iff (rst)
        (regReq.write && regReq.addr == 8'h69 && !regReq.wrData[0]) |=>
            !s.trimStart ##1 (!offsetTrimActive && !offsetResult.write)[*2];
    endproperty
    a_abort: assert property (p_abort) // [R9]
        else $error("Trim kept running after an abort.");

    property p_done_flag;
        @(posedge core_clk) disable iff (rst)
        offsetResult.write |=> offsetTrimDoneFlag && !s.trimStart;
    endproperty
    a_done_flag: assert property (p_done_flag) // [R7]
        else $error("Done flag missing after completion.");

    property p_irq_gate;
        @(posedge core_clk) disable iff (rst)
        trimDoneInterrupt |-> offsetTrimDoneFlag && $past(trimDoneInterruptEnable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) // [R8]
        else $error("Interrupt raised while disabled.");

    property p_sync_high;
        @(posedge core_clk) disable iff (rst)
        (regReq.write && regReq.addr == 8'h50) |=>
            syncDelay[14:8] == $past(regReq.wrData[6:0]) && $stable(syncDelay[7:0]);
    endproperty
    a_sync_high: assert property (p_sync_high) // [R10]
        else $error("Upper sync delay bits not stored.");

    property p_reserved;
        @(posedge core_clk) disable iff (rst)
        (regReq.read && regReq.addr == 8'h53) |=> regRdData[7:4] == 4'h1 && !regRdData[2];
    endproperty
    a_reserved: assert property (p_reserved) // [R11]
        else $error("Reserved bits read wrong value.");

endmodule

// *** verification/pvsc_front_end_model.sv ***
// Behavioural model of the proximity front-end comparator seen by the trim search.
`timescale 1ns/1ps

module pvsc_front_end_model #(
    parameter logic [8:0] TARGET = 9'h15A
) (
    input  wire logic                         core_clk,
    input  wire logic                         offsetTrimActive,
    input  wire logic [pvsc_pkg::OFFSET_BITS-1:0] offsetTrial,
    output logic                              offsetCmpHigh
);
    // ----------
    // Comparator
    // ----------
    // High while the trial is at or below the target, so a correct search lands on it.
    // Outside a search the output toggles each cycle, so stale levels are never trusted.
    initial offsetCmpHigh = 1'b0;
    always @(posedge core_clk) begin
        if (offsetTrimActive) begin
            offsetCmpHigh <= (offsetTrial <= TARGET);
        end else begin
            offsetCmpHigh <= ~offsetCmpHigh;
        end
    end
endmodule

// *** verification/pvsc_regs_bench.sv ***
// Self-checking bench for the frame-sync and offset-trim register bank.
`timescale 1ns/1ps

module pvsc_regs_bench;
    import pvsc_pkg::*;

    localparam logic [8:0] TARGET = 9'h15A;
    logic                   core_clk = 1'b0;
    logic                   rst = 1'b1;
    pvsc_reg_req_t          regReq = '0;
    logic [7:0]             regRdData;
    logic                   powerOnBit = 1'b0;
    logic                   oscTrimIdle = 1'b1;
    logic                   irqEnable = 1'b1;
    logic                   flagClear = 1'b0;
    logic                   cmpHigh;
    logic [14:0]            syncDelay;
    logic                   bypass;
    logic [1:0]             trimMode;
    logic [5:0]             rateCode;
    logic [7:0]             rateHz;
    logic [7:0]             firstDly;
    logic [7:0]             secondDly;
    logic                   oscReq;
    logic                   active;
    logic [OFFSET_BITS-1:0] trial;
    pvsc_offset_wr_t        result;
    logic                   doneFlag;
    logic                   irq;
    int                     fails = 0;
    int                     checksDone = 0;
    int                     pulses = 0;
    int                     n;
    logic [7:0] addrs  [8] = '{8'h4F, 8'h50, 8'h53, 8'h54, 8'h56, 8'h57, 8'h69, 8'h55};
    logic [7:0] rstVal [8] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ffVal  [8] = '{8'hFF, 8'h7F, 8'h1B, 8'h3F, 8'hFF, 8'hFF, 8'h00, 8'h00};
    logic [5:0] codes  [4] = '{6'h00, 6'h01, 6'h1F, 6'h3F};

    // Free-running core clock at 100 MHz.
    always #5 core_clk = ~core_clk;

    pvsc_regs dut (.core_clk(core_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
        .powerOnBit(powerOnBit), .oscTrimIdle(oscTrimIdle),
        .trimDoneInterruptEnable(irqEnable), .trimDoneFlagClear(flagClear),
        .offsetCmpHigh(cmpHigh), .syncDelay(syncDelay), .frameRateLowLimitBypass(bypass),
        .oscillatorTrimMode(trimMode), .frameRateCode(rateCode), .frameRateHz(rateHz),
        .firstBurstStartDelay(firstDly), .secondBurstStartDelay(secondDly),
        .oscTrimRequest(oscReq), .offsetTrimActive(active), .offsetTrial(trial),
        .offsetResult(result), .offsetTrimDoneFlag(doneFlag), .trimDoneInterrupt(irq));

    pvsc_front_end_model #(.TARGET(TARGET)) front (.core_clk(core_clk),
        .offsetTrimActive(active), .offsetTrial(trial), .offsetCmpHigh(cmpHigh));

    // Counts result write pulses so an aborted search can be shown to store nothing.
    always @(posedge core_clk) begin
        if (result.write === 1'b1) pulses++;
    end

    // ------------
    // Bus and checks
    // ------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{write: 1'b1, read: 1'b0, addr: a, wrData: d};
        @(posedge core_clk);
        regReq <= '0;
    endtask

    // Read data is registered, so it is sampled one edge after the strobe is taken.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regReq <= '{write: 1'b0, read: 1'b1, addr: a, wrData: 8'h00};
        @(posedge core_clk);
        regReq <= '0;
        @(posedge core_clk);
        chk({8'h00, regRdData}, {8'h00, exp}, "read data");
    endtask

    task automatic run_trim(input logic en);
        @(posedge core_clk);
        irqEnable <= en;
        wr(ADDR_OFFSET_TRIM_CTRL, 8'h01);
        rd(ADDR_OFFSET_TRIM_CTRL, 8'h01);
        n = 0;
        while (result.write !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        chk({7'h00, result.high[0], result.low}, {7'h00, TARGET}, "offset");
        chk(result.high[7:1], 0, "offset high pad");
        @(posedge core_clk);
        chk(doneFlag, 1, "done flag");
        chk(irq, en, "interrupt");
        rd(ADDR_OFFSET_TRIM_CTRL, 8'h00);
    endtask

    task automatic clear_flag();
        @(posedge core_clk);
        flagClear <= 1'b1;
        @(posedge core_clk);
        flagClear <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk({doneFlag, irq}, 0, "flag clear");
    endtask

    task automatic complete_run();
        if (fails == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 3200 cycles the sequence needs.
    initial begin
        #200000;
        fails++;
        complete_run();
    end

    // ------------
    // Main sequence
    // ------------
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(rateHz, FREQ_BASE_HZ + FREQ_STEP_HZ * 8'h10, "reset rate");
        for (int i = 0; i < 8; i++) rd(addrs[i], rstVal[i]);
        for (int i = 0; i < 8; i++) if (i != 6) wr(addrs[i], 8'hFF);
        for (int i = 0; i < 8; i++) if (i != 6) rd(addrs[i], ffVal[i]);
        chk({bypass, syncDelay}, 16'hFFFF, "sync delay and bypass");
        chk({firstDly, secondDly}, 16'hFFFF, "burst delays");
        wr(ADDR_SYNC_DELAY_LOW, 8'h34);
        wr(ADDR_SYNC_DELAY_HIGH, 8'h92);
        @(posedge core_clk);
        chk(syncDelay, 16'h1234, "sync delay");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_FRAME_SYNC_FREQ, {2'b11, codes[i]});
            repeat (2) @(posedge core_clk);
            chk(rateCode, codes[i], "rate code");
            chk(rateHz, FREQ_BASE_HZ + FREQ_STEP_HZ * {2'b00, codes[i]}, "rate hz");
        end
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_FRAME_SYNC_CFG0, 8'(m));
            powerOnBit <= 1'b0;
            repeat (6) @(posedge core_clk);
            powerOnBit <= 1'b1;
            n = 0;
            repeat (12) begin
                @(posedge core_clk);
                n += int'(oscReq);
            end
            chk(trimMode, 16'(m), "trim mode");
            chk(16'(n), (m == 1) ? 16'h0001 : (m == 2) ? 16'h000C : 16'h0000, "osc req");
        end
        // Continuous mode must hold off while the oscillator is busy.
        wr(ADDR_FRAME_SYNC_CFG0, 8'h02);
        oscTrimIdle <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(oscReq, 0, "osc busy");
        oscTrimIdle <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(oscReq, 1, "osc free");
        run_trim(1'b1);
        clear_flag();
        run_trim(1'b0);
        irqEnable <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(irq, 1, "late enable");
        clear_flag();
        n = pulses;
        wr(ADDR_OFFSET_TRIM_CTRL, 8'h01);
        repeat (20) @(posedge core_clk);
        wr(ADDR_OFFSET_TRIM_CTRL, 8'h00);
        repeat (3) @(posedge core_clk);
        chk(active, 0, "abort");
        repeat (1100) @(posedge core_clk);
        chk({15'(pulses - n), doneFlag}, 0, "aborted result");
        rd(ADDR_OFFSET_TRIM_CTRL, 8'h00);
        complete_run();
    end
endmodule
